/* File: design/watch_defines.svh */
// timing counts and reset values for the lcd watch controller
`ifndef WATCH_DEFINES_SVH
`define WATCH_DEFINES_SVH
`define OSC_HZ          32768
`define CAL_DIV         32
`define PRESCALE1_DIV   32
`define CLK_HZ          50000000
`define DEBOUNCE_MS     10
`define DEBOUNCE_CYC    ((`CLK_HZ / 1000) * `DEBOUNCE_MS)
`define RST_HOUR        4'hc
`define RST_MIN         6'h00
`define RST_SEC         6'h00
`define RST_DATE        5'h00
`endif

/* File: design/watch_pkg.sv */
// types for the lcd watch controller
package watch_pkg;
  typedef enum logic [1:0] {DISP_HM, DISP_SEC, DISP_DATE} disp_e;
  typedef enum logic [2:0] {SET_OFF, SET_HM, SET_MIN, SET_SEC, SET_HOUR, SET_DATE} set_e;
endpackage

/* File: design/switch_debounce.sv */
// switch debouncer with rising edge pulse
`timescale 1ns/100ps
module switch_debounce #(
  parameter int CYCLES = 500000
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_sw,
  output logic      o_level,
  output logic      o_rise
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        lvl_ff;
  logic        nxt_lvl;
  logic        rise_ff;
  logic        nxt_rise;

  always_comb begin
    nxt_cnt  = 32'h0;
    nxt_lvl  = lvl_ff;
    nxt_rise = 1'b0;
    if (i_sw != lvl_ff) begin
      nxt_cnt = cnt_ff + 32'h1;
      if (cnt_ff >= 32'(CYCLES - 1)) begin
        nxt_cnt  = 32'h0;
        nxt_lvl  = i_sw;
        nxt_rise = i_sw;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_ff  <= 32'h0;
      lvl_ff  <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      lvl_ff  <= nxt_lvl;
      rise_ff <= nxt_rise;
    end
  end

  assign o_level = lvl_ff;
  assign o_rise  = rise_ff;
endmodule

/* File: design/lcd_watch.sv */
// lcd watch controller: timekeeping, mode sequencing, segment decode
`timescale 1ns/100ps
`include "watch_defines.svh"
module lcd_watch #(
  parameter int DEBOUNCE_CYC = `DEBOUNCE_CYC,
  parameter int OSC_HZ       = `OSC_HZ
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_osc,
  input  wire logic       i_fast_test,
  input  wire logic       i_disp_sw,
  input  wire logic       i_set_sw,
  output logic [6:0]      o_seg_d1,
  output logic [6:0]      o_seg_d2,
  output logic [6:0]      o_seg_d3,
  output logic            o_half_digit,
  output logic            o_colon,
  output logic            o_cal_out
);
  // ------------------------------------------------------------
  // switch conditioning
  // ------------------------------------------------------------
  logic disp_lvl;
  logic disp_rise;
  logic set_rise;

  switch_debounce #(.CYCLES(DEBOUNCE_CYC)) u_disp_db (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_sw    (i_disp_sw),
    .o_level (disp_lvl),
    .o_rise  (disp_rise)
  );

  switch_debounce #(.CYCLES(DEBOUNCE_CYC)) u_set_db (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_sw    (i_set_sw),
    .o_level (),
    .o_rise  (set_rise)
  );

  // ------------------------------------------------------------
  // time base
  // ------------------------------------------------------------
  // i_osc is the crystal square wave, sampled synchronously
  logic        osc_d_ff;
  logic        nxt_osc_d;
  logic [4:0]  pre1_ff;
  logic [4:0]  nxt_pre1;
  logic [9:0]  pre2_ff;
  logic [9:0]  nxt_pre2;
  logic        cal_ff;
  logic        nxt_cal;
  logic        osc_tick;
  logic        pre1_tick;
  logic        sec_tick;

  assign osc_tick  = i_osc & ~osc_d_ff;
  // fast test feeds the second prescaler from the system clock
  assign pre1_tick = i_fast_test ? 1'b1 : (osc_tick && pre1_ff == 5'h1f);
  assign sec_tick  = pre1_tick && pre2_ff == 10'h3ff;

  always_comb begin
    nxt_osc_d = i_osc;
    nxt_pre1  = osc_tick ? pre1_ff + 5'h1 : pre1_ff;
    nxt_pre2  = pre1_tick ? pre2_ff + 10'h1 : pre2_ff;
    nxt_cal   = pre1_ff[4];
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      osc_d_ff <= 1'b0;
      pre1_ff  <= 5'h00;
      pre2_ff  <= 10'h000;
      cal_ff   <= 1'b0;
    end else begin
      osc_d_ff <= nxt_osc_d;
      pre1_ff  <= nxt_pre1;
      pre2_ff  <= nxt_pre2;
      cal_ff   <= nxt_cal;
    end
  end

  // ------------------------------------------------------------
  // modes
  // ------------------------------------------------------------
  watch_pkg::disp_e disp_ff;
  watch_pkg::disp_e nxt_disp;
  watch_pkg::set_e  set_ff;
  watch_pkg::set_e  nxt_set;

  always_comb begin
    nxt_disp = disp_ff;
    nxt_set  = set_ff;
    if (set_ff == watch_pkg::SET_OFF) begin
      if (disp_rise) begin
        case (disp_ff)
          watch_pkg::DISP_HM:  nxt_disp = watch_pkg::DISP_SEC;
          watch_pkg::DISP_SEC: nxt_disp = watch_pkg::DISP_DATE;
          default:             nxt_disp = watch_pkg::DISP_HM;
        endcase
      end
      if (set_rise && disp_ff == watch_pkg::DISP_HM) begin
        nxt_set = watch_pkg::SET_MIN;
      end
    end else if (set_rise) begin
      case (set_ff)
        watch_pkg::SET_HM:   nxt_set = watch_pkg::SET_MIN;
        watch_pkg::SET_MIN:  nxt_set = watch_pkg::SET_SEC;
        watch_pkg::SET_SEC:  nxt_set = watch_pkg::SET_HOUR;
        watch_pkg::SET_HOUR: nxt_set = watch_pkg::SET_DATE;
        default:             nxt_set = watch_pkg::SET_OFF;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      disp_ff <= watch_pkg::DISP_HM;
      set_ff  <= watch_pkg::SET_OFF;
    end else begin
      disp_ff <= nxt_disp;
      set_ff  <= nxt_set;
    end
  end

  // ------------------------------------------------------------
  // time counters
  // ------------------------------------------------------------
  // hour 1..12 with 12 as the cleared value; date clears to 0 and wraps from 31 to 1
  logic [5:0] sec_ff;
  logic [5:0] nxt_sec;
  logic [5:0] min_ff;
  logic [5:0] nxt_min;
  logic [3:0] hour_ff;
  logic [3:0] nxt_hour;
  logic       pm_ff;
  logic       nxt_pm;
  logic [4:0] date_ff;
  logic [4:0] nxt_date;
  logic       adv_min;
  logic       adv_hour;
  logic       adv_date;
  logic       sync_hold;

  // in minute, hour and date set modes advance the field on a seconds tick while the switch is held; a sync press steps the minute
  assign sync_hold = set_ff == watch_pkg::SET_SEC && disp_lvl;
  assign adv_min   = (set_ff == watch_pkg::SET_MIN && disp_lvl && sec_tick)
                   || (set_ff == watch_pkg::SET_SEC && disp_rise)
                   || (!sync_hold && sec_tick && sec_ff == 6'd59
                       && set_ff != watch_pkg::SET_MIN);
  assign adv_hour  = (set_ff == watch_pkg::SET_HOUR && disp_lvl && sec_tick)
                   || (adv_min && min_ff == 6'd59 && set_ff != watch_pkg::SET_MIN);
  // a manual hour step does not carry into the date
  assign adv_date  = (set_ff == watch_pkg::SET_DATE && disp_lvl && sec_tick)
                   || (adv_hour && set_ff != watch_pkg::SET_HOUR
                       && hour_ff == 4'd11 && pm_ff);

  always_comb begin
    nxt_sec  = sec_ff;
    nxt_min  = min_ff;
    nxt_hour = hour_ff;
    nxt_pm   = pm_ff;
    nxt_date = date_ff;
    if (sync_hold) begin
      nxt_sec = `RST_SEC;
    end else if (sec_tick) begin
      nxt_sec = (sec_ff == 6'd59) ? 6'h00 : sec_ff + 6'h1;
    end
    if (adv_min) begin
      nxt_min = (min_ff == 6'd59) ? 6'h00 : min_ff + 6'h1;
    end
    if (adv_hour) begin
      nxt_hour = (hour_ff == 4'd12) ? 4'h1 : hour_ff + 4'h1;
      if (hour_ff == 4'd11) begin
        nxt_pm = ~pm_ff;
      end
    end
    if (adv_date) begin
      nxt_date = (date_ff == 5'd31) ? 5'h01 : date_ff + 5'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    // synchronous reset doubles as power-on clear
    if (!i_rst_n) begin
      sec_ff  <= `RST_SEC;
      min_ff  <= `RST_MIN;
      hour_ff <= `RST_HOUR;
      pm_ff   <= 1'b0;
      date_ff <= `RST_DATE;
    end else begin
      sec_ff  <= nxt_sec;
      min_ff  <= nxt_min;
      hour_ff <= nxt_hour;
      pm_ff   <= nxt_pm;
      date_ff <= nxt_date;
    end
  end

  // ------------------------------------------------------------
  // display
  // ------------------------------------------------------------
  function automatic logic [6:0] seg_of(input logic [3:0] d);
    // segment order {a,b,c,d,e,f,g}
    case (d)
      4'h0:    seg_of = 7'h7e;
      4'h1:    seg_of = 7'h30;
      4'h2:    seg_of = 7'h6d;
      4'h3:    seg_of = 7'h79;
      4'h4:    seg_of = 7'h33;
      4'h5:    seg_of = 7'h5b;
      4'h6:    seg_of = 7'h5f;
      4'h7:    seg_of = 7'h70;
      4'h8:    seg_of = 7'h7f;
      4'h9:    seg_of = 7'h7b;
      default: seg_of = 7'h00;
    endcase
  endfunction

  logic [6:0] d1_ff;
  logic [6:0] nxt_d1;
  logic [6:0] d2_ff;
  logic [6:0] nxt_d2;
  logic [6:0] d3_ff;
  logic [6:0] nxt_d3;
  logic       half_ff;
  logic       nxt_half;
  logic       colon_ff;
  logic       nxt_colon;
  logic [5:0] low_val;
  logic       hours_on;

  always_comb begin
    low_val  = min_ff;
    hours_on = 1'b1;
    if (set_ff == watch_pkg::SET_OFF) begin
      if (disp_ff == watch_pkg::DISP_SEC) begin
        low_val  = sec_ff;
        hours_on = 1'b0;
      end else if (disp_ff == watch_pkg::DISP_DATE) begin
        low_val  = {1'b0, date_ff};
        hours_on = 1'b0;
      end
    end else if (set_ff == watch_pkg::SET_SEC) begin
      low_val  = sec_ff;
      hours_on = 1'b0;
    end else if (set_ff == watch_pkg::SET_DATE) begin
      low_val  = {1'b0, date_ff};
      hours_on = 1'b0;
    end
    nxt_d3    = seg_of(4'(low_val % 6'd10));
    nxt_d2    = seg_of(4'(low_val / 6'd10));
    nxt_d1    = hours_on ? seg_of(4'(hour_ff % 4'd10)) : 7'h00;
    nxt_half  = hours_on && hour_ff >= 4'd10;
    // colon doubles as pm flag while setting
    nxt_colon = (set_ff == watch_pkg::SET_OFF) ? pre2_ff[9] : pm_ff;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      d1_ff    <= 7'h00;
      d2_ff    <= 7'h00;
      d3_ff    <= 7'h00;
      half_ff  <= 1'b0;
      colon_ff <= 1'b0;
    end else begin
      d1_ff    <= nxt_d1;
      d2_ff    <= nxt_d2;
      d3_ff    <= nxt_d3;
      half_ff  <= nxt_half;
      colon_ff <= nxt_colon;
    end
  end

  assign o_seg_d1     = d1_ff;
  assign o_seg_d2     = d2_ff;
  assign o_seg_d3     = d3_ff;
  assign o_half_digit = half_ff;
  assign o_colon      = colon_ff;
  assign o_cal_out    = cal_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence sync_press_s;
    set_ff == watch_pkg::SET_SEC && disp_rise;
  endsequence

  sync_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sync_press_s |=> sec_ff == 6'h00) else $error("sync did not clear seconds");
  disp_step_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    disp_rise && set_ff == watch_pkg::SET_OFF && disp_ff == watch_pkg::DISP_HM
    |=> disp_ff == watch_pkg::DISP_SEC) else $error("display mode did not step");
  set_ignore_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    set_rise && set_ff == watch_pkg::SET_OFF && disp_ff != watch_pkg::DISP_HM
    |=> set_ff == watch_pkg::SET_OFF) else $error("set switch not ignored");
  sec_roll_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sec_tick && !sync_hold && sec_ff == 6'd59 |=> sec_ff == 6'h00)
    else $error("seconds did not roll over");
  reset_state_a: assert property (@(posedge i_mclk)
    !i_rst_n |=> hour_ff == 4'hc && min_ff == 6'h00 && !pm_ff && date_ff == 5'h00)
    else $error("reset state wrong");
  colon_pm_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    set_ff != watch_pkg::SET_OFF && $stable(set_ff) |=> o_colon == $past(pm_ff))
    else $error("colon not pm flag");
  cal_div_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !i_fast_test && osc_tick && pre1_ff == 5'h0f |=> ##1 o_cal_out)
    else $error("calibrate output wrong");
  blank_hours_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    set_ff == watch_pkg::SET_OFF && disp_ff == watch_pkg::DISP_SEC
    && $stable(disp_ff) |=> o_seg_d1 == 7'h00) else $error("hours not blanked");
  date_blank_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    set_ff == watch_pkg::SET_OFF && disp_ff == watch_pkg::DISP_DATE
    && $stable(disp_ff) |=> o_seg_d1 == 7'h00 && !o_half_digit)
    else $error("date view hours lit");
  pm_toggle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    adv_hour && hour_ff == 4'd11 |=> hour_ff == 4'hc && pm_ff != $past(pm_ff))
    else $error("pm flag did not toggle at twelve");
  set_step_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    set_rise && set_ff == watch_pkg::SET_MIN |=> set_ff == watch_pkg::SET_SEC)
    else $error("set mode did not step");
endmodule

/* File: tb/watch_partner.sv */
// far-side model: two bouncing push switches and an lcd reader
`timescale 1ns/100ps
module watch_partner (
  input  wire logic       i_mclk,
  input  wire logic [6:0] i_seg_d1,
  input  wire logic [6:0] i_seg_d2,
  input  wire logic [6:0] i_seg_d3,
  input  wire logic       i_half_digit,
  output logic            o_disp_sw,
  output logic            o_set_sw,
  output logic [7:0]      o_hours,
  output logic [7:0]      o_mins
);
  logic [1:0] sw;
  logic [3:0] n1;
  logic [3:0] n2;
  logic [3:0] n3;
  initial sw = 2'b00;
  assign o_disp_sw = sw[0];
  assign o_set_sw  = sw[1];
  // ----------------------------------------
  // lcd reader: blank reads a, unknown reads f
  // ----------------------------------------
  function automatic logic [3:0] seg2num(input logic [6:0] s);
    case (s)
      7'h7e: return 4'h0;
      7'h30: return 4'h1;
      7'h6d: return 4'h2;
      7'h79: return 4'h3;
      7'h33: return 4'h4;
      7'h5b: return 4'h5;
      7'h5f: return 4'h6;
      7'h70: return 4'h7;
      7'h7f: return 4'h8;
      7'h7b: return 4'h9;
      7'h00: return 4'ha;
      default: return 4'hf;
    endcase
  endfunction
  always_comb begin
    n1 = seg2num(i_seg_d1);
    n2 = seg2num(i_seg_d2);
    n3 = seg2num(i_seg_d3);
    if (n1 == 4'ha && i_half_digit === 1'b0) o_hours = 8'hee;
    else if (n1 > 4'h9 || i_half_digit === 1'bx) o_hours = 8'hff;
    else o_hours = {7'h00, i_half_digit} * 8'h0a + {4'h0, n1};
    if (n2 > 4'h9 || n3 > 4'h9) o_mins = 8'hff;
    else o_mins = {4'h0, n2} * 8'h0a + {4'h0, n3};
  end
  // ----------------------------------------
  // switches: contact chatter before a clean closure
  // ----------------------------------------
  task automatic close_sw(input int sel);
    repeat (2) begin
      @(posedge i_mclk);
      #1 sw[sel] = 1'b1;
      @(posedge i_mclk);
      #1 sw[sel] = 1'b0;
    end
    @(posedge i_mclk);
    #1 sw[sel] = 1'b1;
  endtask
  task automatic open_sw(input int sel);
    @(posedge i_mclk);
    #1 sw[sel] = 1'b0;
    repeat (20) @(posedge i_mclk);
  endtask
  // held well past debounce so a stuck level would show as extra steps
  task automatic press(input int sel);
    close_sw(sel);
    repeat (40) @(posedge i_mclk);
    open_sw(sel);
  endtask
endmodule

/* File: tb/lcd_watch_tb.sv */
// self-checking bench for the lcd watch controller
`timescale 1ns/100ps
module lcd_watch_tb;
  logic       i_mclk;
  logic       i_rst_n;
  logic       i_osc;
  logic       i_fast_test;
  logic       osc_run;
  logic       disp_sw;
  logic       set_sw;
  logic [6:0] seg_d1;
  logic [6:0] seg_d2;
  logic [6:0] seg_d3;
  logic       half_digit;
  logic       colon;
  logic       cal_out;
  logic [7:0] hours;
  logic [7:0] mins;
  int         error_cnt;
  int         check_count;
  lcd_watch #(.DEBOUNCE_CYC(4)) dut (
    .i_mclk       (i_mclk),
    .i_rst_n      (i_rst_n),
    .i_osc        (i_osc),
    .i_fast_test  (i_fast_test),
    .i_disp_sw    (disp_sw),
    .i_set_sw     (set_sw),
    .o_seg_d1     (seg_d1),
    .o_seg_d2     (seg_d2),
    .o_seg_d3     (seg_d3),
    .o_half_digit (half_digit),
    .o_colon      (colon),
    .o_cal_out    (cal_out)
  );
  watch_partner p (
    .i_mclk       (i_mclk),
    .i_seg_d1     (seg_d1),
    .i_seg_d2     (seg_d2),
    .i_seg_d3     (seg_d3),
    .i_half_digit (half_digit),
    .o_disp_sw    (disp_sw),
    .o_set_sw     (set_sw),
    .o_hours      (hours),
    .o_mins       (mins)
  );
  // ----------------------------------------
  // clock, crystal stand-in, helpers
  // ----------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  initial begin
    i_osc = 1'b0;
    forever begin
      repeat (4) @(posedge i_mclk);
      #1 i_osc = osc_run & ~i_osc;
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input logic [7:0] h, input int lim);
    int n;
    n = 0;
    while (hours !== h && n < lim) begin
      @(posedge i_mclk);
      n++;
    end
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    check({8'h00, hours}, 16'h000c);
    check({8'h00, mins}, 16'h0000);
  endtask
  task automatic t_display;
    p.press(0);
    check({8'h00, hours}, 16'h00ee);
    check({8'h00, mins}, 16'h0000);
    p.press(0);
    check({8'h00, hours}, 16'h00ee);
    check({8'h00, mins}, 16'h0000);
    p.press(0);
    check({8'h00, hours}, 16'h000c);
  endtask
  task automatic t_set_ignored;
    p.press(0);
    p.press(1);
    check({8'h00, hours}, 16'h00ee);
    p.press(0);
    p.press(0);
    check({8'h00, hours}, 16'h000c);
  endtask
  // seconds view under fast test walks every ones digit
  task automatic t_digits;
    logic [9:0] seen;
    logic       bad;
    seen = '0;
    bad = 1'b0;
    p.press(0);
    #1 i_fast_test = 1'b1;
    repeat (12000) begin
      @(posedge i_mclk);
      if (mins === 8'hff || hours !== 8'hee) bad = 1'b1;
      else seen[mins % 10] = 1'b1;
    end
    check({15'h0000, bad}, 16'h0000);
    check({6'h00, seen}, 16'h03ff);
    p.press(0);
    p.press(0);
  endtask
  task automatic t_set_walk;
    logic [7:0] m0;
    p.press(1);
    m0 = mins;
    p.close_sw(0);
    repeat (3584) @(posedge i_mclk);
    p.open_sw(0);
    check({15'h0000, (mins - m0 == 8'h03) || (mins - m0 == 8'h04)}, 16'h0001);
    m0 = mins;
    p.press(1);
    // sync view shows seconds, which must sit at zero while held
    p.close_sw(0);
    repeat (2048) @(posedge i_mclk);
    check({8'h00, mins}, 16'h0000);
    p.open_sw(0);
    p.press(1);
    check({8'h00, mins}, {8'h00, m0 + 8'h01});
    p.close_sw(0);
    wait_for(8'h0b, 15000);
    check({7'h00, hours, colon}, 16'h0016);
    wait_for(8'h0c, 2000);
    check({7'h00, hours, colon}, 16'h0019);
    p.open_sw(0);
    p.press(1);
    m0 = mins;
    p.close_sw(0);
    repeat (2048) @(posedge i_mclk);
    p.open_sw(0);
    check({15'h0000, (mins - m0 == 8'h02) || (mins - m0 == 8'h03)}, 16'h0001);
    p.press(1);
  endtask
  task automatic t_colon;
    logic last;
    int   tg;
    tg = 0;
    last = colon;
    repeat (2048) begin
      @(posedge i_mclk);
      if (colon !== last) tg++;
      last = colon;
    end
    check(tg[15:0], 16'h0004);
    @(posedge i_mclk);
    #1 i_rst_n = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1 i_rst_n = 1'b1;
    repeat (3) @(posedge i_mclk);
    check({hours, mins}, 16'h0c00);
    #1 i_fast_test = 1'b0;
  endtask
  task automatic t_cal;
    int n;
    osc_run = 1'b1;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (cal_out !== 1'b1 && n < 600) begin
        @(posedge i_mclk);
        n++;
      end
      while (cal_out !== 1'b0 && n < 600) begin
        @(posedge i_mclk);
        n++;
      end
    end
    n = 0;
    while (cal_out !== 1'b1 && n < 600) begin
      @(posedge i_mclk);
      n++;
    end
    while (cal_out !== 1'b0 && n < 600) begin
      @(posedge i_mclk);
      n++;
    end
    check(n[15:0], 16'h0100);
    osc_run = 1'b0;
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    error_cnt = 0;
    check_count = 0;
    osc_run = 1'b0;
    i_fast_test = 1'b0;
    i_rst_n = 1'b0;
    repeat (4) @(posedge i_mclk);
    #1 i_rst_n = 1'b1;
    repeat (3) @(posedge i_mclk);
    t_reset();
    t_display();
    t_set_ignored();
    t_digits();
    t_set_walk();
    t_colon();
    t_cal();
    report_and_stop();
  end
  initial begin
    repeat (60000) @(posedge i_mclk);
    error_cnt++;
    report_and_stop();
  end
endmodule
